// [src/tmr2_top.sv]
// sixteen-bit timer with capture, reload, up/down and baud-tick steering
`include "tmr2_defs.svh"
`default_nettype none
module tmr2_top (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // single-bit access to the control register
  input wire logic bit_wr,
  input wire logic [2:0] bit_sel,
  input wire logic bit_value,
  // interrupt enable in, request out
  input wire logic irq_enable,
  output logic timer_irq,
  // pins
  input wire logic external_trigger_pin,
  input wire logic count_input_pin_in,
  output logic count_input_pin_out,
  output logic count_input_pin_oe_n,
  // serial port clocking
  input wire logic other_timer_ovf,
  output logic rx_baud_tick,
  output logic tx_baud_tick
);
  tmr2_pkg::tmr2_state_t st, next_st;
  logic ext_level, ext_fall, cnt_fall, tick12, tick2;

  // steer a serial clock: this overflow or the other timer's
  function automatic logic pick_tick(input logic sel, input logic own,
                                     input logic other);
    pick_tick = sel ? own : other;
  endfunction

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  tmr2_pin_sync u_ext_sync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .pin(external_trigger_pin),
    .level(ext_level),
    .fall(ext_fall)
  );

  tmr2_pin_sync u_cnt_sync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .pin(count_input_pin_in),
    .level(),
    .fall(cnt_fall)
  );

  tmr2_prescale u_pre (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .tick12(tick12),
    .tick2(tick2)
  );

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  logic baud, updn, cap_mode, tick, adv, up, ovf, unf, trig;
  logic ovf_set, ext_set, ext_tgl;

  // decode operating mode and counting events
  always_comb begin
    baud = st.ctrl[`TMR2_B_RCLK] | st.ctrl[`TMR2_B_TRANSMIT_CLOCK_SELECT];
    cap_mode = st.ctrl[`TMR2_B_CPRL] & ~baud;
    updn = st.mode[`TMR2_B_UPDN] & ~cap_mode & ~baud;
    if (st.ctrl[`TMR2_B_CTS]) begin
      tick = cnt_fall;
    end else if (baud | st.mode[`TMR2_B_OE]) begin
      tick = tick2;
    end else begin
      tick = tick12;
    end
    adv = st.ctrl[`TMR2_B_RUN] & tick;
    up = ~updn | ext_level;
    ovf = adv & up & (st.count == `TMR2_COUNT_MAX);
    unf = adv & ~up & (st.count == st.reload);
    // trigger edges count only when enabled, not serving serial and not counting up/down
    trig = st.ctrl[`TMR2_B_EXEN] & ext_fall & ~baud & ~updn;
    ovf_set = ovf & ~baud;
    ext_set = trig;
    ext_tgl = updn & (ovf | unf);
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.rdata = 8'h00;
    // counter: both bytes advance as one word
    if (ovf) begin
      next_st.count = cap_mode ? `TMR2_COUNT_ZERO : st.reload;
    end else if (unf) begin
      next_st.count = `TMR2_COUNT_MAX;
    end else if (adv) begin
      next_st.count = up ? st.count + `TMR2_COUNT_ONE
                         : st.count - `TMR2_COUNT_ONE;
    end
    // trigger: capture into reload pair, or reload the counter
    if (trig && cap_mode) begin
      next_st.reload = st.count;
    end else if (trig) begin
      next_st.count = st.reload;
    end
    // clock output toggles on each overflow in clock-out mode
    if (ovf && st.mode[`TMR2_B_OE]) begin
      next_st.clk_out = ~st.clk_out;
    end
    next_st.pin_oe_n = ~st.mode[`TMR2_B_OE];
    // software writes, counter writes win over counting
    if (reg_wr) begin
      unique case (reg_addr)
        `TMR2_ADDR_CTRL: next_st.ctrl = reg_wdata;
        `TMR2_ADDR_MODE: next_st.mode = reg_wdata[1:0];
        `TMR2_ADDR_RLD_LO: next_st.reload[7:0] = reg_wdata;
        `TMR2_ADDR_RLD_HI: next_st.reload[15:8] = reg_wdata;
        `TMR2_ADDR_CNT_LO: next_st.count[7:0] = reg_wdata;
        `TMR2_ADDR_CNT_HI: next_st.count[15:8] = reg_wdata;
        default: next_st.ctrl = st.ctrl;
      endcase
    end
    if (bit_wr) begin
      next_st.ctrl[bit_sel] = bit_value;
    end
    // hardware sets win over a software clear in the same cycle
    if (ovf_set) begin
      next_st.ctrl[`TMR2_B_OVF] = 1'b1;
    end
    if (ext_set) begin
      next_st.ctrl[`TMR2_B_EXT] = 1'b1;
    end
    if (ext_tgl) begin
      next_st.ctrl[`TMR2_B_EXT] = ~next_st.ctrl[`TMR2_B_EXT];
    end
    // request from overflow flag outside clock-out mode, or external flag outside up/down
    next_st.irq = irq_enable & ((next_st.ctrl[`TMR2_B_OVF] &
                  ~st.mode[`TMR2_B_OE]) |
                  (next_st.ctrl[`TMR2_B_EXT] & ~updn));
    next_st.rx_tick = pick_tick(st.ctrl[`TMR2_B_RCLK], ovf,
                                other_timer_ovf);
    next_st.tx_tick = pick_tick(st.ctrl[`TMR2_B_TRANSMIT_CLOCK_SELECT], ovf,
                                other_timer_ovf);
    // read data, unmapped addresses read zero
    if (reg_rd) begin
      unique case (reg_addr)
        `TMR2_ADDR_CTRL: next_st.rdata = st.ctrl;
        `TMR2_ADDR_MODE: next_st.rdata = {6'h00, st.mode};
        `TMR2_ADDR_RLD_LO: next_st.rdata = st.reload[7:0];
        `TMR2_ADDR_RLD_HI: next_st.rdata = st.reload[15:8];
        `TMR2_ADDR_CNT_LO: next_st.rdata = st.count[7:0];
        `TMR2_ADDR_CNT_HI: next_st.rdata = st.count[15:8];
        default: next_st.rdata = 8'h00;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
      st.ctrl <= `TMR2_CTRL_RESET;
      st.pin_oe_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign reg_rdata = st.rdata;
  assign timer_irq = st.irq;
  assign rx_baud_tick = st.rx_tick;
  assign tx_baud_tick = st.tx_tick;
  assign count_input_pin_out = st.clk_out;
  assign count_input_pin_oe_n = st.pin_oe_n;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  // control register comes out of reset cleared
  a_reset_ctrl: assert property ($rose(arst_n) |->
    st.ctrl == `TMR2_CTRL_RESET)
    else $error("control register not cleared by reset");

  // single-bit port lands on the selected bit
  a_bit_write: assert property (bit_wr && !ovf_set && !ext_set &&
    !ext_tgl |=> st.ctrl[$past(bit_sel)] == $past(bit_value))
    else $error("single-bit write lost");

  // trigger edge raises the external flag
  a_ext_flag_set: assert property (trig |=> st.ctrl[`TMR2_B_EXT])
    else $error("external flag not set by trigger");

  // flag with enable requests the interrupt outside up/down, software writes excluded
  a_irq_from_ext: assert property (st.ctrl[`TMR2_B_EXT] &&
    irq_enable && !updn && $stable(st.ctrl) && !reg_wr && !bit_wr
    |=> timer_irq)
    else $error("external flag did not request interrupt");

  // outside up/down counting hardware never clears the external flag
  a_ext_sticky: assert property (st.ctrl[`TMR2_B_EXT] && !updn &&
    !reg_wr && !bit_wr |=> st.ctrl[`TMR2_B_EXT])
    else $error("external flag cleared by hardware");

  // up/down counting keeps the external flag off the request
  a_updn_no_irq: assert property (updn &&
    !next_st.ctrl[`TMR2_B_OVF] |=> !timer_irq)
    else $error("external flag requested interrupt in up/down mode");

  // overflow flag stays until software clears it
  a_flag_sticky: assert property (st.ctrl[`TMR2_B_OVF] &&
    !reg_wr && !bit_wr |=> st.ctrl[`TMR2_B_OVF])
    else $error("overflow flag cleared by hardware");

  // overflow sets the flag outside serial clocking
  a_ovf_flag: assert property (ovf && !baud |=>
    st.ctrl[`TMR2_B_OVF])
    else $error("overflow flag missing");

  // serial clocking never sets the overflow flag
  a_no_baud_flag: assert property (baud &&
    !st.ctrl[`TMR2_B_OVF] && !reg_wr && !bit_wr |=> !st.ctrl[`TMR2_B_OVF])
    else $error("overflow flag set in serial mode");

  // ----------------------------------------------------------------
  // checks: serial clock steering
  // ----------------------------------------------------------------
  // receive select set: receiver follows this overflow
  a_rx_steer: assert property (st.ctrl[`TMR2_B_RCLK] |=>
    rx_baud_tick == $past(ovf))
    else $error("receive tick not from own overflow");

  // receive select clear: receiver follows the other timer
  a_rx_other: assert property (!st.ctrl[`TMR2_B_RCLK] |=>
    rx_baud_tick == $past(other_timer_ovf))
    else $error("receive tick not from other timer");

  // transmit select set: transmitter follows this overflow
  a_tx_own: assert property (st.ctrl[`TMR2_B_TRANSMIT_CLOCK_SELECT] |=>
    tx_baud_tick == $past(ovf))
    else $error("transmit tick not from own overflow");

  // transmit select clear: transmitter follows the other timer
  a_tx_steer: assert property (!st.ctrl[`TMR2_B_TRANSMIT_CLOCK_SELECT] |=>
    tx_baud_tick == $past(other_timer_ovf))
    else $error("transmit tick not from other timer");

  // serial clocking forces reload on overflow
  a_force_reload: assert property (baud && ovf && !reg_wr |=>
    st.count == $past(st.reload))
    else $error("serial mode overflow did not reload");

  // ----------------------------------------------------------------
  // checks: counting and trigger
  // ----------------------------------------------------------------
  // trigger pin ignored while its enable is clear
  a_trig_ignored: assert property (!st.ctrl[`TMR2_B_EXEN]
    |-> !trig)
    else $error("trigger acted while disabled");

  // trigger edge in reload mode loads the count from the reload pair
  a_trig_reload: assert property (trig && !cap_mode && !reg_wr |=>
    st.count == $past(st.reload))
    else $error("trigger did not reload the count");

  // stopped counter holds its value
  a_run_gate: assert property (!st.ctrl[`TMR2_B_RUN] &&
    !reg_wr && !trig |=> $stable(st.count))
    else $error("counter moved while stopped");

  // each enabled tick while counting up moves the count up by one
  a_run_advance: assert property (adv && up && !ovf &&
    !reg_wr && !trig |=> st.count == $past(st.count) + `TMR2_COUNT_ONE)
    else $error("counter did not advance");

  // counter mode moves only on a filtered pin fall
  a_count_pin: assert property (st.ctrl[`TMR2_B_CTS] &&
    !cnt_fall && !reg_wr && !trig |=> $stable(st.count))
    else $error("counter moved without a pin fall");

  // timer mode outside serial and clock-out moves only on the divide-by-twelve enable
  a_timer_rate: assert property (!st.ctrl[`TMR2_B_CTS] && !baud &&
    !st.mode[`TMR2_B_OE] && !tick12 && !reg_wr && !trig
    |=> $stable(st.count))
    else $error("timer moved off the divided clock");

  // low byte carry advances the high byte
  a_byte_carry: assert property (adv && up && !ovf &&
    (&st.count[7:0]) && !reg_wr && !trig |=>
    st.count[15:8] == $past(st.count[15:8]) + 8'h01)
    else $error("high byte missed the carry");

  // capture copies the running count into the reload pair
  a_capture: assert property (trig && cap_mode && !reg_wr |=>
    st.reload == $past(st.count))
    else $error("capture did not copy count");

  // capture leaves the count itself alone
  a_capture_hold: assert property (trig && cap_mode && !adv &&
    !reg_wr |=> $stable(st.count))
    else $error("capture disturbed the count");
endmodule // tmr2_top
`default_nettype wire

// [src/tmr2_defs.svh]
// constants of the sixteen-bit timer control block
`ifndef TMR2_DEFS_SVH
`define TMR2_DEFS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define TMR2_ADDR_CTRL 8'hc8
`define TMR2_ADDR_MODE 8'hc9
`define TMR2_ADDR_RLD_LO 8'hca
`define TMR2_ADDR_RLD_HI 8'hcb
`define TMR2_ADDR_CNT_LO 8'hcc
`define TMR2_ADDR_CNT_HI 8'hcd
`define TMR2_CTRL_RESET 8'h00

// ----------------------------------------------------------------
// control and mode bit positions
// ----------------------------------------------------------------
`define TMR2_B_OVF 7
`define TMR2_B_EXT 6
`define TMR2_B_RCLK 5
`define TMR2_B_TRANSMIT_CLOCK_SELECT 4
`define TMR2_B_EXEN 3
`define TMR2_B_RUN 2
`define TMR2_B_CTS 1
`define TMR2_B_CPRL 0
`define TMR2_B_OE 1
`define TMR2_B_UPDN 0

// ----------------------------------------------------------------
// counting constants
// ----------------------------------------------------------------
`define TMR2_COUNT_MAX 16'hffff
`define TMR2_COUNT_ZERO 16'h0000
`define TMR2_COUNT_ONE 16'h0001
`define TMR2_PRESCALE_LAST 4'hb
`define TMR2_PRESCALE_ZERO 4'h0

`endif

// [src/tmr2_pkg.sv]
// state types of the timer control block
`default_nettype none
package tmr2_pkg;
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic fall;
  } tmr2_sync_t;

  typedef struct packed {
    logic [3:0] cnt;
    logic half;
    logic tick12;
    logic tick2;
  } tmr2_pre_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [1:0] mode;
    logic [15:0] count;
    logic [15:0] reload;
    logic [7:0] rdata;
    logic irq;
    logic rx_tick;
    logic tx_tick;
    logic clk_out;
    logic pin_oe_n;
  } tmr2_state_t;
endpackage
`default_nettype wire

// [src/tmr2_pin_sync.sv]
// three-stage pin synchroniser with agreement filter and fall detect
`default_nettype none
module tmr2_pin_sync (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // pin side
  input wire logic pin,
  // filtered level and one-cycle falling-edge pulse
  output logic level,
  output logic fall
);
  tmr2_pkg::tmr2_sync_t st, next_st;

  // ----------------------------------------------------------------
  // filter: level moves only when stages two and three agree
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.s1 = pin;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.fall = 1'b0;
    if (st.s2 == st.s3) begin
      next_st.level = st.s3;
      next_st.fall = st.level & ~st.s3;
    end
  end

  // state register, pins idle high
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, level: 1'b1, fall: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign level = st.level;
  assign fall = st.fall;
endmodule // tmr2_pin_sync
`default_nettype wire

// [src/tmr2_prescale.sv]
// oscillator divider giving divide-by-twelve and divide-by-two enables
`include "tmr2_defs.svh"
`default_nettype none
module tmr2_prescale (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // one-cycle enables
  output logic tick12,
  output logic tick2
);
  tmr2_pkg::tmr2_pre_t st, next_st;

  // divider counters
  always_comb begin
    next_st = st;
    next_st.half = ~st.half;
    next_st.tick2 = st.half;
    next_st.tick12 = (st.cnt == `TMR2_PRESCALE_LAST);
    if (st.cnt == `TMR2_PRESCALE_LAST) begin
      next_st.cnt = `TMR2_PRESCALE_ZERO;
    end else begin
      next_st.cnt = st.cnt + 4'h1;
    end
  end

  // state register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick12 = st.tick12;
  assign tick2 = st.tick2;
endmodule // tmr2_prescale
`default_nettype wire

// [dv/tmr2_pin_model.sv]
// far-side drivers for the trigger pin, count pin and other timer overflow
`default_nettype none
module tmr2_pin_model (
  // clock
  input wire logic clk_sys,
  // pins and overflow seen by the timer block
  output logic trig_pin,
  output logic cnt_pin,
  output logic other_ovf
);
  timeunit 1ns;
  timeprecision 1ps;
  // pins idle high, overflow idle low
  initial begin
    trig_pin = 1'b1;
    cnt_pin = 1'b1;
    other_ovf = 1'b0;
  end
  // falling edge on one pin, held past the pin filter, then released
  task automatic fall_pin(input logic sel);
    @(posedge clk_sys);
    if (sel) cnt_pin <= 1'b0;
    else trig_pin <= 1'b0;
    repeat (8) @(posedge clk_sys);
    cnt_pin <= 1'b1;
    trig_pin <= 1'b1;
    repeat (8) @(posedge clk_sys);
  endtask
  // hold the trigger pin at one level, it sets the up/down direction
  task automatic hold_trig(input logic v);
    @(posedge clk_sys) trig_pin <= v;
  endtask
  // one-cycle overflow pulse of the other timer
  task automatic ovf_pulse();
    @(posedge clk_sys) other_ovf <= 1'b1;
    @(posedge clk_sys) other_ovf <= 1'b0;
  endtask
endmodule // tmr2_pin_model
`default_nettype wire

// [dv/timer2_control_logic_test.sv]
// self-checking bench of the timer control block
`include "tmr2_defs.svh"
`default_nettype none
module timer2_control_logic_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, arst_n, reg_wr, reg_rd, bit_wr, bit_value, irq_enable;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d, e;
  logic [2:0] bit_sel;
  logic timer_irq, trig, cnt, oovf, oe_n, rx_t, tx_t, pout;
  int num_errors = 0;
  int samples_checked = 0;
  int rx_n = 0;
  int tx_n = 0;
  int rx0, tx0;
  // -----------------------------------------
  // clock, block and far side
  // -----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  tmr2_top dut (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .bit_wr(bit_wr), .bit_sel(bit_sel),
    .bit_value(bit_value), .irq_enable(irq_enable), .timer_irq(timer_irq),
    .external_trigger_pin(trig), .count_input_pin_in(cnt),
    .count_input_pin_out(pout), .count_input_pin_oe_n(oe_n),
    .other_timer_ovf(oovf), .rx_baud_tick(rx_t), .tx_baud_tick(tx_t));
  tmr2_pin_model pm (.clk_sys(clk_sys), .trig_pin(trig), .cnt_pin(cnt),
    .other_ovf(oovf));
  // count serial ticks
  always @(posedge clk_sys) begin
    rx_n <= rx_n + int'(rx_t);
    tx_n <= tx_n + int'(tx_t);
  end
  // -----------------------------------------
  // bus, compare and closing tasks
  // -----------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys) reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys) reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic bw(input logic [2:0] s, input logic v);
    @(posedge clk_sys);
    bit_wr <= 1'b1;
    bit_sel <= s;
    bit_value <= v;
    @(posedge clk_sys) bit_wr <= 1'b0;
  endtask
  task automatic irq_is(input logic v);
    @(posedge clk_sys);
    #1 chk({7'h00, timer_irq}, {7'h00, v});
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // -----------------------------------------
  // scenarios
  // -----------------------------------------
  task automatic t_reset();
    chk({7'h00, oe_n}, 8'h01);
    rd(`TMR2_ADDR_CTRL, d); chk(d, `TMR2_CTRL_RESET);
    rd(8'hc0, d); chk(d, 8'h00);
    bw(3'd5, 1'b1);
    rd(`TMR2_ADDR_CTRL, d); chk(d, 8'h20);
    bw(3'd5, 1'b0);
  endtask
  task automatic t_overflow();
    int n;
    wr(`TMR2_ADDR_CNT_LO, 8'hfe);
    wr(`TMR2_ADDR_CNT_HI, 8'hff);
    wr(`TMR2_ADDR_RLD_LO, 8'h34);
    wr(`TMR2_ADDR_RLD_HI, 8'h12);
    bw(3'd2, 1'b1);
    n = 0;
    while (timer_irq !== 1'b1 && n < 200) begin
      @(posedge clk_sys);
      #1 n++;
    end
    if (n == 200) begin
      num_errors++;
      wrap_up();
    end
    rd(`TMR2_ADDR_CTRL, d); chk(d, 8'h84);
    rd(`TMR2_ADDR_CNT_HI, d); chk(d, 8'h12);
    bw(3'd2, 1'b0);
    rd(`TMR2_ADDR_CNT_LO, d);
    repeat (30) @(posedge clk_sys);
    rd(`TMR2_ADDR_CNT_LO, e); chk(e, d);
    bw(3'd7, 1'b0);
    irq_is(1'b0);
  endtask
  task automatic t_trigger();
    pm.fall_pin(1'b0);
    rd(`TMR2_ADDR_CTRL, d); chk(d, 8'h00);
    wr(`TMR2_ADDR_CTRL, 8'h09);
    wr(`TMR2_ADDR_CNT_LO, 8'h56);
    wr(`TMR2_ADDR_CNT_HI, 8'h78);
    pm.fall_pin(1'b0);
    rd(`TMR2_ADDR_CTRL, d); chk(d, 8'h49);
    rd(`TMR2_ADDR_RLD_LO, d); chk(d, 8'h56);
    rd(`TMR2_ADDR_RLD_HI, d); chk(d, 8'h78);
    irq_is(1'b1);
    bw(3'd0, 1'b0);
    wr(`TMR2_ADDR_MODE, 8'h01);
    irq_is(1'b0);
    wr(`TMR2_ADDR_MODE, 8'h00);
    wr(`TMR2_ADDR_CTRL, 8'h00);
    irq_is(1'b0);
  endtask
  task automatic t_counter();
    wr(`TMR2_ADDR_CNT_LO, 8'hff);
    wr(`TMR2_ADDR_CNT_HI, 8'h00);
    wr(`TMR2_ADDR_CTRL, 8'h06);
    repeat (3) pm.fall_pin(1'b1);
    rd(`TMR2_ADDR_CNT_LO, d); chk(d, 8'h02);
    rd(`TMR2_ADDR_CNT_HI, d); chk(d, 8'h01);
    wr(`TMR2_ADDR_CTRL, 8'h00);
  endtask
  task automatic t_serial();
    rx0 = rx_n;
    tx0 = tx_n;
    pm.ovf_pulse();
    repeat (3) @(posedge clk_sys);
    chk(8'(rx_n - rx0), 8'h01);
    chk(8'(tx_n - tx0), 8'h01);
    wr(`TMR2_ADDR_RLD_LO, 8'hf0);
    wr(`TMR2_ADDR_RLD_HI, 8'hff);
    wr(`TMR2_ADDR_CNT_LO, 8'hf0);
    wr(`TMR2_ADDR_CNT_HI, 8'hff);
    rx0 = rx_n;
    tx0 = tx_n;
    wr(`TMR2_ADDR_CTRL, 8'h35);
    repeat (200) @(posedge clk_sys);
    wr(`TMR2_ADDR_CTRL, 8'h00);
    chk({7'h00, (rx_n - rx0) > 4}, 8'h01);
    chk({7'h00, (tx_n - tx0) > 4}, 8'h01);
    rd(`TMR2_ADDR_CTRL, d); chk(d, 8'h00);
  endtask
  task automatic t_clock_out();
    int n;
    wr(`TMR2_ADDR_RLD_LO, 8'hf8);
    wr(`TMR2_ADDR_RLD_HI, 8'hff);
    wr(`TMR2_ADDR_CNT_LO, 8'hf8);
    wr(`TMR2_ADDR_CNT_HI, 8'hff);
    wr(`TMR2_ADDR_MODE, 8'h02);
    wr(`TMR2_ADDR_CTRL, 8'h04);
    chk({7'h00, oe_n}, 8'h00);
    n = 0;
    d = 8'h00;
    while (d[7] !== 1'b1 && n < 50) begin
      rd(`TMR2_ADDR_CTRL, d);
      n++;
    end
    if (d[7] !== 1'b1) begin
      num_errors++;
      wrap_up();
    end
    bw(3'd2, 1'b0);
    irq_is(1'b0);
    chk({7'h00, pout}, 8'h01);
    wr(`TMR2_ADDR_CTRL, 8'h00);
    wr(`TMR2_ADDR_MODE, 8'h00);
  endtask
  task automatic t_updown();
    wr(`TMR2_ADDR_RLD_LO, 8'h10);
    wr(`TMR2_ADDR_RLD_HI, 8'h00);
    wr(`TMR2_ADDR_CNT_LO, 8'h12);
    wr(`TMR2_ADDR_CNT_HI, 8'h00);
    wr(`TMR2_ADDR_MODE, 8'h01);
    pm.hold_trig(1'b0);
    repeat (6) @(posedge clk_sys);
    wr(`TMR2_ADDR_CTRL, 8'h04);
    repeat (60) @(posedge clk_sys);
    bw(3'd2, 1'b0);
    rd(`TMR2_ADDR_CNT_HI, d); chk(d, 8'hff);
    rd(`TMR2_ADDR_CTRL, d); chk(d & 8'h40, 8'h40);
    irq_is(1'b0);
    wr(`TMR2_ADDR_CTRL, 8'h00);
    wr(`TMR2_ADDR_MODE, 8'h00);
    pm.hold_trig(1'b1);
  endtask
  // reset, then every scenario in turn
  initial begin
    arst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    bit_wr = 1'b0;
    bit_sel = 3'h0;
    bit_value = 1'b0;
    irq_enable = 1'b1;
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_reset();
    t_overflow();
    t_trigger();
    t_counter();
    t_serial();
    t_clock_out();
    t_updown();
    wrap_up();
  end
endmodule // timer2_control_logic_test
`default_nettype wire
